// ### rtl/dsx_pkg.sv
package dsx_pkg;

   localparam logic [5:0]  OPC_SKIP_ZERO    = 6'h0b;
   localparam logic [5:0]  OPC_SKIP_NONZERO = 6'h13;
   localparam int          OPC_MSB          = 15;
   localparam int          OPC_LSB          = 10;
   localparam int          DEST_BIT         = 9;
   localparam int          ACCESS_BIT       = 8;
   localparam int          FILE_MSB         = 7;
   localparam logic [7:0]  ACCESS_SPLIT     = 8'h80;
   localparam logic [7:0]  INDEXED_LIMIT    = 8'h5f;
   localparam logic [3:0]  SFR_PAGE         = 4'hf;
   localparam logic [3:0]  LOW_PAGE         = 4'h0;
   localparam logic [7:0]  ONE_BYTE         = 8'h01;
   localparam logic [1:0]  SQUASH_ONE_WORD  = 2'h1;
   localparam logic [1:0]  SQUASH_TWO_WORD  = 2'h2;
   localparam logic [11:0] ADDR_RESET       = 12'h000;
   localparam logic [7:0]  DATA_RESET       = 8'h00;

   typedef struct packed {
      logic [5:0] opcode;
      logic       dest;
      logic       access;
      logic [7:0] file;
   } dsx_instr_t;

   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [7:0]  data;
   } dsx_fwr_t;

   typedef enum logic [1:0] {
      DSX_IDLE   = 2'b00,
      DSX_READ   = 2'b01,
      DSX_SQUASH = 2'b10
   } dsx_state_t;

endpackage

// ### rtl/dsx_addr_resolve.sv
`timescale 1ns/1ps
module dsx_addr_resolve
(
   input  wire logic [7:0]  file_i,
   input  wire logic        access_i,
   input  wire logic        ext_set_en_i,
   input  wire logic [3:0]  bank_select_reg_i,
   input  wire logic [11:0] index_base_i,
   output logic      [11:0] addr_o
);
   import dsx_pkg::*;

   always_comb begin
      if (access_i) begin
         addr_o = {bank_select_reg_i, file_i};
      end else if (ext_set_en_i && file_i <= INDEXED_LIMIT) begin
         addr_o = 12'(index_base_i + {4'h0, file_i});
      end else if (file_i >= ACCESS_SPLIT) begin
         addr_o = {SFR_PAGE, file_i};
      end else begin
         addr_o = {LOW_PAGE, file_i};
      end
   end
endmodule // dsx_addr_resolve

// ### rtl/dsx_exec.sv
`timescale 1ns/1ps
module dsx_exec
(
   input  wire logic                clk_i,
   input  wire logic                nrst_i,
   input  wire logic [15:0]         instr_i,
   input  wire logic                instr_valid_i,
   input  wire logic                next_two_word_i,
   input  wire logic                ext_set_en_i,
   input  wire logic [3:0]          bank_select_reg_i,
   input  wire logic [11:0]         index_base_i,
   input  wire logic [7:0]          file_rdata_i,
   output logic                     ready_o,
   output logic                     rd_en_o,
   output logic [11:0]              rd_addr_o,
   output dsx_pkg::dsx_fwr_t        file_wr_o,
   output logic                     wreg_we_o,
   output logic [7:0]               wreg_wdata_o,
   output logic                     squash_o,
   output logic                     done_o
);
   import dsx_pkg::*;

   dsx_instr_t  dec;
   dsx_state_t  state;
   dsx_state_t  next_state;
   logic [11:0] res_addr;
   logic        is_ours;
   logic        accept;
   logic        zero_variant;
   logic        next_zero_variant;
   logic        dest;
   logic        next_dest;
   logic [1:0]  squash_cnt;
   logic [1:0]  next_squash_cnt;
   logic [7:0]  result;
   logic        skip;
   logic        next_ready;
   logic        next_rd_en;
   logic [11:0] next_rd_addr;
   dsx_fwr_t    next_file_wr;
   logic        next_wreg_we;
   logic [7:0]  next_wreg_wdata;
   logic        next_squash;
   logic        next_done;

   assign dec     = dsx_instr_t'(instr_i);
   // Foreign opcodes are left for other execution units, so they are not taken here.
   assign is_ours = (dec.opcode == OPC_SKIP_ZERO) || (dec.opcode == OPC_SKIP_NONZERO);
   assign accept  = (state == DSX_IDLE) && instr_valid_i && is_ours;
   assign result  = file_rdata_i - ONE_BYTE;
   assign skip    = zero_variant ? (result == DATA_RESET)
                                 : (result != DATA_RESET);

   dsx_addr_resolve i_dsx_addr_resolve (
      .file_i            (dec.file),
      .access_i          (dec.access),
      .ext_set_en_i      (ext_set_en_i),
      .bank_select_reg_i (bank_select_reg_i),
      .index_base_i      (index_base_i),
      .addr_o            (res_addr)
   );

   always_comb begin
      next_state        = state;
      next_zero_variant = zero_variant;
      next_dest         = dest;
      next_squash_cnt   = squash_cnt;
      next_ready        = 1'b0;
      next_rd_en        = 1'b0;
      next_rd_addr      = rd_addr_o;
      next_file_wr      = '{en: 1'b0, addr: rd_addr_o, data: file_wr_o.data};
      next_wreg_we      = 1'b0;
      next_wreg_wdata   = wreg_wdata_o;
      next_squash       = 1'b0;
      next_done         = 1'b0;
      case (state)
         DSX_IDLE: begin
            next_ready = 1'b1;
            if (accept) begin
               next_ready        = 1'b0;
               next_zero_variant = (dec.opcode == OPC_SKIP_ZERO);
               next_dest         = dec.dest;
               next_rd_en        = 1'b1;
               next_rd_addr      = res_addr;
               next_state        = DSX_READ;
            end
         end
         DSX_READ: begin
            next_done = 1'b1;
            if (dest) begin
               next_file_wr = '{en: 1'b1, addr: rd_addr_o, data: result};
            end else begin
               next_wreg_we    = 1'b1;
               next_wreg_wdata = result;
            end
            if (skip) begin
               // The fetch stage already holds the next word; it must become a no-operation.
               next_squash     = 1'b1;
               next_squash_cnt = next_two_word_i ? SQUASH_TWO_WORD : SQUASH_ONE_WORD;
               next_state      = DSX_SQUASH;
            end else begin
               next_ready = 1'b1;
               next_state = DSX_IDLE;
            end
         end
         DSX_SQUASH: begin
            next_squash_cnt = squash_cnt - 2'h1;
            if (squash_cnt == SQUASH_ONE_WORD) begin
               next_ready = 1'b1;
               next_state = DSX_IDLE;
            end else begin
               next_squash = 1'b1;
            end
         end
         default: begin
            next_state = DSX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state        <= DSX_IDLE;
         zero_variant <= 1'b0;
         dest         <= 1'b0;
         squash_cnt   <= 2'h0;
         ready_o      <= 1'b0;
         rd_en_o      <= 1'b0;
         rd_addr_o    <= ADDR_RESET;
         file_wr_o    <= '{en: 1'b0, addr: ADDR_RESET, data: DATA_RESET};
         wreg_we_o    <= 1'b0;
         wreg_wdata_o <= DATA_RESET;
         squash_o     <= 1'b0;
         done_o       <= 1'b0;
      end else begin
         state        <= next_state;
         zero_variant <= next_zero_variant;
         dest         <= next_dest;
         squash_cnt   <= next_squash_cnt;
         ready_o      <= next_ready;
         rd_en_o      <= next_rd_en;
         rd_addr_o    <= next_rd_addr;
         file_wr_o    <= next_file_wr;
         wreg_we_o    <= next_wreg_we;
         wreg_wdata_o <= next_wreg_wdata;
         squash_o     <= next_squash;
         done_o       <= next_done;
      end
   end

   property p_read_result;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) |=> done_o &&
         ((file_wr_o.en && file_wr_o.data == $past(file_rdata_i) - ONE_BYTE) ||
          (wreg_we_o && wreg_wdata_o == $past(file_rdata_i) - ONE_BYTE));
   endproperty
   a_read_result: assert property (p_read_result) else $error("Result is not the read value minus one.");

   property p_dest_wreg;
      @(posedge clk_i) disable iff (!nrst_i)
      accept && !dec.dest |=> ##1 wreg_we_o && !file_wr_o.en;
   endproperty
   a_dest_wreg: assert property (p_dest_wreg) else $error("Destination 0 did not write only W.");

   property p_dest_file;
      @(posedge clk_i) disable iff (!nrst_i)
      accept && dec.dest |=> ##1 file_wr_o.en && !wreg_we_o && file_wr_o.addr == $past(rd_addr_o);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("Destination 1 did not write the file back.");

   property p_skip_zero;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) && zero_variant |=> squash_o == ($past(file_rdata_i) == ONE_BYTE);
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("Zero variant skip decision wrong.");

   property p_skip_nonzero;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) && !zero_variant |=> squash_o == ($past(file_rdata_i) != ONE_BYTE);
   endproperty
   a_skip_nonzero: assert property (p_skip_nonzero) else $error("Nonzero variant skip decision wrong.");

   property p_two_word;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) && skip && next_two_word_i |=> squash_o[*2] ##1 (!squash_o && ready_o);
   endproperty
   a_two_word: assert property (p_two_word) else $error("Two-word skip did not squash two cycles.");

   property p_one_word;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) && skip && !next_two_word_i |=> squash_o ##1 (!squash_o && ready_o);
   endproperty
   a_one_word: assert property (p_one_word) else $error("One-word skip did not squash one cycle.");

   property p_no_skip;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_READ) && !skip |=> !squash_o && ready_o;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("Squash seen without a skip.");

   property p_banked;
      @(posedge clk_i) disable iff (!nrst_i)
      accept && dec.access |=> rd_en_o && rd_addr_o == {$past(bank_select_reg_i), $past(dec.file)};
   endproperty
   a_banked: assert property (p_banked) else $error("Banked address not formed from bank select.");

   property p_access_bank;
      @(posedge clk_i) disable iff (!nrst_i)
      accept && !dec.access && !ext_set_en_i |=>
         rd_addr_o == {($past(dec.file) >= ACCESS_SPLIT) ? SFR_PAGE : LOW_PAGE, $past(dec.file)};
   endproperty
   a_access_bank: assert property (p_access_bank) else $error("Access bank address wrong.");

   property p_indexed;
      @(posedge clk_i) disable iff (!nrst_i)
      accept && !dec.access && ext_set_en_i && dec.file <= INDEXED_LIMIT |=>
         rd_addr_o == 12'($past(index_base_i) + {4'h0, $past(dec.file)});
   endproperty
   a_indexed: assert property (p_indexed) else $error("Indexed offset address wrong.");

   property p_decode;
      @(posedge clk_i) disable iff (!nrst_i)
      (state == DSX_IDLE) && instr_valid_i && !is_ours |=> !rd_en_o;
   endproperty
   a_decode: assert property (p_decode) else $error("Foreign opcode was taken.");

   c_two_word: cover property (@(posedge clk_i) disable iff (!nrst_i) squash_o ##1 squash_o);
   c_one_skip: cover property (@(posedge clk_i) disable iff (!nrst_i) done_o && squash_o ##1 !squash_o);
   c_wreg:     cover property (@(posedge clk_i) disable iff (!nrst_i) wreg_we_o && !squash_o);
   c_indexed:  cover property (@(posedge clk_i) disable iff (!nrst_i) accept && ext_set_en_i && !dec.access);
endmodule // dsx_exec

// ### dv/dsx_exec_tb_top.sv
`timescale 1ns/1ps
module dsx_exec_tb_top;
   import dsx_pkg::*;

   logic        clk_i;
   logic        nrst_i;
   logic [15:0] instr_i;
   logic        instr_valid_i;
   logic        next_two_word_i;
   logic        ext_set_en_i;
   logic [3:0]  bank_select_reg_i;
   logic [11:0] index_base_i;
   logic [7:0]  file_rdata_i;
   logic        ready_o;
   logic        rd_en_o;
   logic [11:0] rd_addr_o;
   dsx_fwr_t    file_wr_o;
   logic        wreg_we_o;
   logic [7:0]  wreg_wdata_o;
   logic        squash_o;
   logic        done_o;
   int          fails;
   int          total_checks;

   dsx_exec i_dsx_exec (.clk_i(clk_i), .nrst_i(nrst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .next_two_word_i(next_two_word_i), .ext_set_en_i(ext_set_en_i), .bank_select_reg_i(bank_select_reg_i),
      .index_base_i(index_base_i), .file_rdata_i(file_rdata_i), .ready_o(ready_o), .rd_en_o(rd_en_o),
      .rd_addr_o(rd_addr_o), .file_wr_o(file_wr_o), .wreg_we_o(wreg_we_o), .wreg_wdata_o(wreg_wdata_o),
      .squash_o(squash_o), .done_o(done_o));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h", $time, msg, got);
      end
   endtask

   // Bounded wait, since a hung sequencer would otherwise stall the run forever.
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      if (ready_o !== 1'b1) begin
         chk_bit(ready_o, 1'b1, "ready timeout");
         complete_run();
      end
   endtask

   task automatic run_op(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                         input logic [7:0] v, input logic tw, input logic ext, input logic [3:0] bank,
                         input logic [11:0] base, input logic [11:0] exp_addr);
      logic [7:0] res;
      logic       skip;
      int         n;
      res = v - ONE_BYTE;
      skip = (opc == OPC_SKIP_ZERO) ? (res == 8'h00) : (res != 8'h00);
      wait_ready();
      @(posedge clk_i);
      instr_i <= {opc, d, a, f};
      instr_valid_i <= 1'b1;
      ext_set_en_i <= ext;
      bank_select_reg_i <= bank;
      index_base_i <= base;
      file_rdata_i <= v;
      next_two_word_i <= tw;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk_bit(rd_en_o, 1'b1, "read pulse");
      chk_val(rd_addr_o, exp_addr, "read address");
      chk_bit(ready_o, 1'b0, "busy while executing");
      @(negedge clk_i);
      chk_bit(done_o, 1'b1, "done pulse");
      chk_bit(file_wr_o.en, d, "file write enable");
      chk_bit(wreg_we_o, ~d, "working write enable");
      if (d) begin
         chk_val({4'h0, file_wr_o.data}, {4'h0, res}, "file write data");
         chk_val(file_wr_o.addr, exp_addr, "file write address");
      end else begin
         chk_val({4'h0, wreg_wdata_o}, {4'h0, res}, "working write data");
      end
      n = 0;
      while (squash_o === 1'b1 && n < 4) begin
         n++;
         @(negedge clk_i);
      end
      chk_val(12'(n), skip ? (tw ? 12'h002 : 12'h001) : 12'h000, "squash count");
      chk_bit(ready_o, 1'b1, "ready after completion");
   endtask

   task automatic test_skip_zero();
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h12, 8'h01, 1'b0, 1'b0, 4'h3, 12'h000, 12'h312);
      run_op(OPC_SKIP_ZERO, 1'b0, 1'b1, 8'h12, 8'h05, 1'b1, 1'b0, 4'h3, 12'h000, 12'h312);
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b1, 8'hff, 8'h01, 1'b1, 1'b0, 4'hc, 12'h000, 12'hcff);
      $display("test skip_zero done");
   endtask

   task automatic test_skip_nonzero();
      run_op(OPC_SKIP_NONZERO, 1'b1, 1'b1, 8'h40, 8'h00, 1'b1, 1'b0, 4'h1, 12'h000, 12'h140);
      run_op(OPC_SKIP_NONZERO, 1'b0, 1'b1, 8'h40, 8'h01, 1'b0, 1'b0, 4'h1, 12'h000, 12'h140);
      run_op(OPC_SKIP_NONZERO, 1'b0, 1'b1, 8'h41, 8'h80, 1'b0, 1'b0, 4'h1, 12'h000, 12'h141);
      $display("test skip_nonzero done");
   endtask

   task automatic test_addressing();
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b0, 8'h20, 8'h07, 1'b0, 1'b0, 4'h5, 12'h300, 12'h020);
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b0, 8'h80, 8'h07, 1'b0, 1'b0, 4'h5, 12'h300, 12'hf80);
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b0, 8'h5f, 8'h07, 1'b0, 1'b1, 4'h5, 12'h300, 12'h35f);
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b0, 8'h60, 8'h07, 1'b0, 1'b1, 4'h5, 12'h300, 12'h060);
      run_op(OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h10, 8'h07, 1'b0, 1'b1, 4'h5, 12'h300, 12'h510);
      run_op(OPC_SKIP_NONZERO, 1'b1, 1'b0, 8'h00, 8'h02, 1'b0, 1'b1, 4'h5, 12'hff8, 12'hff8);
      $display("test addressing done");
   endtask

   task automatic test_refused();
      int i;
      wait_ready();
      @(posedge clk_i);
      instr_i <= {6'h0a, 1'b1, 1'b1, 8'h12};
      instr_valid_i <= 1'b1;
      for (i = 0; i < 3; i++) begin
         @(negedge clk_i);
         chk_bit(rd_en_o | done_o, 1'b0, "foreign opcode acted on");
      end
      @(posedge clk_i);
      instr_i <= {OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h12};
      instr_valid_i <= 1'b0;
      for (i = 0; i < 3; i++) begin
         @(negedge clk_i);
         chk_bit(rd_en_o, 1'b0, "invalid word acted on");
      end
      $display("test refused done");
   endtask

   task automatic test_reset();
      wait_ready();
      @(posedge clk_i);
      instr_i         <= {OPC_SKIP_ZERO, 1'b1, 1'b1, 8'h12};
      instr_valid_i   <= 1'b1;
      file_rdata_i    <= 8'h01;
      next_two_word_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk_bit(rd_en_o, 1'b0, "word taken while busy");
      chk_bit(squash_o, 1'b1, "squash before reset");
      @(posedge clk_i);
      nrst_i        <= 1'b0;
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk_bit(squash_o | done_o | rd_en_o | wreg_we_o | file_wr_o.en | ready_o, 1'b0, "reset left outputs set");
      chk_val(rd_addr_o, ADDR_RESET, "reset read address");
      @(posedge clk_i);
      nrst_i <= 1'b1;
      wait_ready();
      chk_bit(squash_o, 1'b0, "squash survived reset");
      $display("test reset done");
   endtask

   initial begin
      fails = 0;
      total_checks = 0;
      nrst_i = 1'b0;
      instr_i = 16'h0000;
      instr_valid_i = 1'b0;
      next_two_word_i = 1'b0;
      ext_set_en_i = 1'b0;
      bank_select_reg_i = 4'h0;
      index_base_i = 12'h000;
      file_rdata_i = 8'h00;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      test_skip_zero();
      test_skip_nonzero();
      test_addressing();
      test_refused();
      test_reset();
      complete_run();
   end
endmodule // dsx_exec_tb_top
